// ===== rtl/rtc_cal_cfg.svh
// Register addresses, field positions, reset values and bus codes of the calendar block.
`ifndef RTC_CAL_CFG_SVH
`define RTC_CAL_CFG_SVH

// Register byte addresses on the bus.
`define ADDR_HOUR_MODE      32'h50000404
`define ADDR_CAL_DATE       32'h5000040C
`define ADDR_TIME_ALARM     32'h50000410
`define ADDR_CAL_ALARM      32'h50000414
`define ADDR_ALARM_EN       32'h50000418
`define ADDR_EVENT_FLAGS    32'h5000041C

// Reset values.
`define CAL_DATE_RST        32'h2000010F
`define TIME_ALARM_RST      32'h00000000
`define CAL_ALARM_RST       32'h00000000
`define ALARM_EN_RST        6'h00

// Writable bits of each register; everything else reads as zero, except the calendar change flag in bit 31.
`define CAL_DATE_MASK       32'h3FFF3FFF
`define TIME_ALARM_MASK     32'h7F7F7FFF
`define CAL_ALARM_MASK      32'h00003FF8

// Bit positions and field ranges.
`define CHANGED_BIT         31
`define HOUR_MODE_BIT       0
`define ALARM_FLAG_BIT      6
`define ALARM_EN_F          5:0
`define EN_MONTH            5
`define EN_DATE             4
`define EN_HOUR             3
`define EN_MIN              2
`define EN_SEC              1
`define EN_HOS              0
`define HOUR12_F            30:24
`define HOUR24_F            29:24
`define MIN_F               22:16
`define SEC_F               14:8
`define HOS_F               7:0
`define DATE_F              13:8
`define MONTH_F             7:3
`define CT_F                29:28
`define CU_F                27:24
`define YT_F                23:20
`define YU_F                19:16
`define DT_F                13:12
`define DU_F                11:8
`define MT_F                7
`define MU_F                6:3
`define DAY_F               2:0

// Digit limits.
`define CT_MIN              2'h1
`define CT_MAX              2'h2
`define DT_MAX              2'h3
`define DIGIT_MAX           4'h9

// Bus response codes.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== rtl/rtc_cal_pkg.sv
// Types shared by the calendar block: bus channel states and the register state record.
package rtc_cal_pkg;

	// Write channel progress, one-hot.
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;

	// Read channel progress, one-hot.
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;

	// Every flip-flop of the calendar block.
	typedef struct packed {
		wr_state_t   wr;          // Write channel state.
		rd_state_t   rd;          // Read channel state.
		logic        aw_have;     // Write address captured.
		logic        w_have;      // Write data captured.
		logic [31:0] aw_addr;     // Captured write address.
		logic [31:0] wdata;       // Captured write data.
		logic [3:0]  wstrb;       // Captured byte strobes.
		logic        awready;     // Address ready output.
		logic        wready;      // Data ready output.
		logic        bvalid;      // Write response valid.
		logic [1:0]  bresp;       // Write response code.
		logic        arready;     // Read address ready.
		logic        rvalid;      // Read data valid.
		logic [1:0]  rresp;       // Read response code.
		logic [31:0] rdata;       // Read data.
		logic [31:0] cal_date;    // Calendar value with change flag.
		logic [31:0] time_alarm;  // Time alarm match value.
		logic [31:0] cal_alarm;   // Calendar alarm match value.
		logic [5:0]  alarm_en;    // Per-field alarm enables.
		logic        twelve_hour; // Twelve-hour mode select.
		logic        alarm_flag;  // Sticky alarm event flag.
		logic        match_prev;  // Match seen in the last cycle.
	} cal_state_t;

endpackage

// ===== rtl/cal_field_guard.sv
// Keeps each calendar digit inside its legal range, holding the old digit otherwise.
`timescale 1ns/100ps
`include "rtc_cal_cfg.svh"

module cal_field_guard (
	input  wire logic [31:0] old_value, // Calendar value now held.
	input  wire logic [31:0] proposed,  // Value that is to be loaded.
	output logic      [31:0] guarded    // Value after range checks.
);

	// A digit out of range keeps the old one, so one bad byte lane cannot poison others.
	always_comb
	begin
		guarded = proposed & `CAL_DATE_MASK;
		if (proposed[`CT_F] < `CT_MIN || proposed[`CT_F] > `CT_MAX)
			guarded[`CT_F] = old_value[`CT_F];
		if (proposed[`CU_F] > `DIGIT_MAX)
			guarded[`CU_F] = old_value[`CU_F];
		if (proposed[`YT_F] > `DIGIT_MAX)
			guarded[`YT_F] = old_value[`YT_F];
		if (proposed[`YU_F] > `DIGIT_MAX)
			guarded[`YU_F] = old_value[`YU_F];
		if (proposed[`DT_F] > `DT_MAX)
			guarded[`DT_F] = old_value[`DT_F];
		if (proposed[`DU_F] > `DIGIT_MAX)
			guarded[`DU_F] = old_value[`DU_F];
		if (proposed[`MU_F] > `DIGIT_MAX)
			guarded[`MU_F] = old_value[`MU_F];
	end

endmodule

// ===== rtl/alarm_matcher.sv
// Compares the enabled alarm fields with the current time and calendar.
`timescale 1ns/100ps
`include "rtc_cal_cfg.svh"

module alarm_matcher (
	input  wire logic [31:0] time_now,    // Current time value.
	input  wire logic [31:0] cal_now,     // Current calendar value.
	input  wire logic [31:0] time_alarm,  // Time alarm match value.
	input  wire logic [31:0] cal_alarm,   // Calendar alarm match value.
	input  wire logic [5:0]  enables,     // Per-field alarm enables.
	input  wire logic        twelve_hour, // Twelve-hour mode select.
	output logic             match        // All enabled fields agree.
);

	logic hour_ok; // Hour field agrees.

	// The afternoon bit only means something in twelve-hour mode.
	assign hour_ok = twelve_hour ? (time_now[`HOUR12_F] == time_alarm[`HOUR12_F])
		: (time_now[`HOUR24_F] == time_alarm[`HOUR24_F]);

	// No enable set means no alarm at all, never a permanent match.
	assign match = (|enables)
		& (!enables[`EN_MONTH] | (cal_now[`MONTH_F] == cal_alarm[`MONTH_F]))
		& (!enables[`EN_DATE] | (cal_now[`DATE_F] == cal_alarm[`DATE_F]))
		& (!enables[`EN_HOUR] | hour_ok)
		& (!enables[`EN_MIN] | (time_now[`MIN_F] == time_alarm[`MIN_F]))
		& (!enables[`EN_SEC] | (time_now[`SEC_F] == time_alarm[`SEC_F]))
		& (!enables[`EN_HOS] | (time_now[`HOS_F] == time_alarm[`HOS_F]));

endmodule

// ===== rtl/rtc_calendar_alarm.sv
// Calendar register, alarm match registers and alarm flag behind an AXI4-Lite slave.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`include "rtc_cal_cfg.svh"

// Summary of operation
// - Calendar change sets top flag; read clears it.
// - Century tens BCD one to two, reset two.
// - Century units BCD zero to nine, reset zero.
// - Year tens and units BCD, reset zero.
// - Date tens zero to three, units; reset one.
// - Month tens bit, units digit; reset month one.
// - Day of week code, reset seven.
// - Time alarm holds afternoon bit and hours.
// - Time alarm holds minutes, tens field three bits, unchecked.
// - Time alarm holds seconds, reset zero.
// - Time alarm holds hundredths, reset zero.
// - Calendar alarm holds date and month, reset zero.
// - Month enable requires month equality for alarm.
// - Date enable requires date equality for alarm.
// - Hour enable compares hours; afternoon bit only in twelve-hour mode.
// - Minute enable compares both minute digits.
// - Second enable compares both seconds digits.
// - Hundredths enable compares hundredths; enables reset zero.
// - Hour mode selects twelve or twenty-four hours.
// - Alarm match sets read-only alarm event flag.
module rtc_calendar_alarm (
	input  wire logic        aclk,               // Clock, 125 MHz.
	input  wire logic        aresetn,            // Synchronous reset, active low.
	input  wire logic        ce,                 // Clock enable; low freezes all state.
	input  wire logic [31:0] awaddr,             // Write address.
	input  wire logic        awvalid,            // Write address valid.
	output logic             awready,            // Write address ready.
	input  wire logic [31:0] wdata,              // Write data.
	input  wire logic [3:0]  wstrb,              // Write byte strobes.
	input  wire logic        wvalid,             // Write data valid.
	output logic             wready,             // Write data ready.
	output logic [1:0]       bresp,              // Write response.
	output logic             bvalid,             // Write response valid.
	input  wire logic        bready,             // Write response ready.
	input  wire logic [31:0] araddr,             // Read address.
	input  wire logic        arvalid,            // Read address valid.
	output logic             arready,            // Read address ready.
	output logic [31:0]      rdata,              // Read data.
	output logic [1:0]       rresp,              // Read response.
	output logic             rvalid,             // Read data valid.
	input  wire logic        rready,             // Read data ready.
	input  wire logic [31:0] time_now,           // Current time from the time counter.
	input  wire logic        cal_load,           // Pulse: time counter loads a new calendar.
	input  wire logic [31:0] cal_load_value,     // Calendar value to load.
	output logic [31:0]      calendar_value,     // Calendar register as held.
	output logic             twelve_hour_select, // Twelve-hour mode select.
	output logic             alarm_event_flag    // Sticky alarm event flag.
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Merges write data into a register under the byte strobes.
	function automatic logic [31:0] apply_strb(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] strb);
		logic [31:0] res; // Merged word.
		res = old_word;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_word[i*8 +: 8];
		end
		return res;
	endfunction

	// Word-aligned copy of a bus address, so the low two bits never matter.
	function automatic logic [31:0] word_addr(input logic [31:0] a);
		return {a[31:2], 2'b00};
	endfunction

	// True for any address that holds a register of this block.
	function automatic logic addr_known(input logic [31:0] a);
		logic [31:0] w; // Aligned address.
		w = word_addr(a);
		return (w == `ADDR_HOUR_MODE) || (w == `ADDR_CAL_DATE)
			|| (w == `ADDR_TIME_ALARM) || (w == `ADDR_CAL_ALARM)
			|| (w == `ADDR_ALARM_EN) || (w == `ADDR_EVENT_FLAGS);
	endfunction

	// Read value of a register; unmapped addresses read zero.
	function automatic logic [31:0] read_word(input logic [31:0] a,
		input rtc_cal_pkg::cal_state_t s);
		logic [31:0] res; // Word returned.
		res = 32'h00000000;
		case (word_addr(a))
			`ADDR_HOUR_MODE:   res[`HOUR_MODE_BIT] = s.twelve_hour;
			`ADDR_CAL_DATE:    res = s.cal_date;
			`ADDR_TIME_ALARM:  res = s.time_alarm;
			`ADDR_CAL_ALARM:   res = s.cal_alarm;
			`ADDR_ALARM_EN:    res[`ALARM_EN_F] = s.alarm_en;
			`ADDR_EVENT_FLAGS: res[`ALARM_FLAG_BIT] = s.alarm_flag;
			default:           res = 32'h00000000;
		endcase
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State and reset value

	// Reset image of every flip-flop; ready outputs come up high so the bus can start.
	localparam rtc_cal_pkg::cal_state_t ST_RESET = '{
		wr:          rtc_cal_pkg::WR_IDLE,
		rd:          rtc_cal_pkg::RD_IDLE,
		aw_have:     1'b0,
		w_have:      1'b0,
		aw_addr:     32'h00000000,
		wdata:       32'h00000000,
		wstrb:       4'h0,
		awready:     1'b1,
		wready:      1'b1,
		bvalid:      1'b0,
		bresp:       `RESP_OKAY,
		arready:     1'b1,
		rvalid:      1'b0,
		rresp:       `RESP_OKAY,
		rdata:       32'h00000000,
		cal_date:    `CAL_DATE_RST,
		time_alarm:  `TIME_ALARM_RST,
		cal_alarm:   `CAL_ALARM_RST,
		alarm_en:    `ALARM_EN_RST,
		twelve_hour: 1'b0,
		alarm_flag:  1'b0,
		match_prev:  1'b0
	};

	rtc_cal_pkg::cal_state_t st_r;   // All registered state.
	rtc_cal_pkg::cal_state_t st_nxt; // Next value of the state.

	logic        aw_hs;        // Write address taken this cycle.
	logic        w_hs;         // Write data taken this cycle.
	logic        ar_hs;        // Read address taken this cycle.
	logic [31:0] eff_addr;     // Write address, fresh or captured.
	logic [31:0] eff_data;     // Write data, fresh or captured.
	logic [3:0]  eff_strb;     // Write strobes, fresh or captured.
	logic        do_write;     // Both halves present: perform the write.
	logic        cal_sw_write; // Software writes the calendar.
	logic [31:0] cal_proposed; // Calendar value offered to the guard.
	logic [31:0] cal_guarded;  // Calendar value after range checks.
	logic        cal_update;   // Calendar is loaded this cycle.
	logic        cal_changed;  // Loaded calendar differs from the held one.
	logic        cal_read;     // Software reads the calendar this cycle.
	logic        alarm_match;  // All enabled alarm fields agree.

	////////////////////////////////////////////////////////////////////////////////
	// Handshakes and write operands

	// A channel moves when its valid meets our registered ready.
	assign aw_hs = awvalid & st_r.awready;
	assign w_hs  = wvalid & st_r.wready;
	assign ar_hs = arvalid & st_r.arready;

	// Address and data may arrive in either order; use whichever copy is current.
	assign eff_addr = aw_hs ? awaddr : st_r.aw_addr;
	assign eff_data = w_hs ? wdata : st_r.wdata;
	assign eff_strb = w_hs ? wstrb : st_r.wstrb;
	assign do_write = (st_r.wr == rtc_cal_pkg::WR_IDLE)
		&& (st_r.aw_have || aw_hs) && (st_r.w_have || w_hs);

	////////////////////////////////////////////////////////////////////////////////
	// Calendar loading

	// Software wins over the time counter when both load in one cycle.
	assign cal_sw_write = do_write && (word_addr(eff_addr) == `ADDR_CAL_DATE);
	assign cal_proposed = cal_sw_write ? apply_strb(st_r.cal_date, eff_data, eff_strb)
		: cal_load_value;
	assign cal_update   = cal_sw_write || cal_load;
	assign cal_read     = ar_hs && (word_addr(araddr) == `ADDR_CAL_DATE);

	// Only the calendar fields are compared; the flag bit itself is not a change.
	assign cal_changed = cal_update
		&& ((cal_guarded & `CAL_DATE_MASK) != (st_r.cal_date & `CAL_DATE_MASK));

	// Range checks on every calendar digit.
	cal_field_guard u_guard (
		.old_value (st_r.cal_date),
		.proposed  (cal_proposed),
		.guarded   (cal_guarded)
	);

	// Alarm comparison against the live time and the held calendar.
	alarm_matcher u_match (
		.time_now    (time_now),
		.cal_now     (st_r.cal_date),
		.time_alarm  (st_r.time_alarm),
		.cal_alarm   (st_r.cal_alarm),
		.enables     (st_r.alarm_en),
		.twelve_hour (st_r.twelve_hour),
		.match       (alarm_match)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Fills the next state from the bus, the calendar load and the alarm match.
	always_comb
	begin
		st_nxt = st_r;

		// The flag is sticky; it is set on the first cycle of a match only.
		st_nxt.match_prev = alarm_match;
		if (alarm_match && !st_r.match_prev)
			st_nxt.alarm_flag = 1'b1;

		// Capture each half of a write as it comes and drop its ready.
		if (aw_hs)
		begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = awaddr;
			st_nxt.awready = 1'b0;
		end
		if (w_hs)
		begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata  = wdata;
			st_nxt.wstrb  = wstrb;
			st_nxt.wready = 1'b0;
		end

		// New calendar value; the flag bit is handled below.
		if (cal_update)
			st_nxt.cal_date[30:0] = cal_guarded[30:0];

		// A change in the same cycle as a read wins, so no change is lost.
		if (cal_changed)
			st_nxt.cal_date[`CHANGED_BIT] = 1'b1;
		else if (cal_read)
			st_nxt.cal_date[`CHANGED_BIT] = 1'b0;

		// Write channel: perform the write, then hold the response until taken.
		case (st_r.wr)
			rtc_cal_pkg::WR_IDLE:
			begin
				if (do_write)
				begin
					st_nxt.aw_have = 1'b0;
					st_nxt.w_have  = 1'b0;
					st_nxt.awready = 1'b0;
					st_nxt.wready  = 1'b0;
					st_nxt.bvalid  = 1'b1;
					st_nxt.wr      = rtc_cal_pkg::WR_RESP;
					st_nxt.bresp   = addr_known(eff_addr) ? `RESP_OKAY : `RESP_SLVERR;
					case (word_addr(eff_addr))
						`ADDR_HOUR_MODE:
						begin
							if (eff_strb[0])
								st_nxt.twelve_hour = eff_data[`HOUR_MODE_BIT];
						end
						`ADDR_TIME_ALARM:
						begin
							st_nxt.time_alarm = apply_strb(st_r.time_alarm, eff_data,
								eff_strb) & `TIME_ALARM_MASK;
						end
						`ADDR_CAL_ALARM:
						begin
							st_nxt.cal_alarm = apply_strb(st_r.cal_alarm, eff_data,
								eff_strb) & `CAL_ALARM_MASK;
						end
						`ADDR_ALARM_EN:
						begin
							if (eff_strb[0])
								st_nxt.alarm_en = eff_data[`ALARM_EN_F];
						end
						// Calendar is written above; event flags are read-only.
						default:
						begin
							st_nxt.alarm_en = st_r.alarm_en;
						end
					endcase
				end
			end
			rtc_cal_pkg::WR_RESP:
			begin
				// Both readies return only after the response has gone.
				if (bready)
				begin
					st_nxt.bvalid  = 1'b0;
					st_nxt.awready = 1'b1;
					st_nxt.wready  = 1'b1;
					st_nxt.wr      = rtc_cal_pkg::WR_IDLE;
				end
			end
			default:
			begin
				st_nxt.wr = rtc_cal_pkg::WR_IDLE;
			end
		endcase

		// Read channel: one read at a time, data held until taken.
		case (st_r.rd)
			rtc_cal_pkg::RD_IDLE:
			begin
				if (ar_hs)
				begin
					st_nxt.rdata   = read_word(araddr, st_r);
					st_nxt.rresp   = addr_known(araddr) ? `RESP_OKAY : `RESP_SLVERR;
					st_nxt.rvalid  = 1'b1;
					st_nxt.arready = 1'b0;
					st_nxt.rd      = rtc_cal_pkg::RD_DATA;
				end
			end
			rtc_cal_pkg::RD_DATA:
			begin
				if (rready)
				begin
					st_nxt.rvalid  = 1'b0;
					st_nxt.arready = 1'b1;
					st_nxt.rd      = rtc_cal_pkg::RD_IDLE;
				end
			end
			default:
			begin
				st_nxt.rd = rtc_cal_pkg::RD_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Reset wins over the clock enable; a low enable freezes everything.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= ST_RESET;
		else if (ce)
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign awready            = st_r.awready;
	assign wready             = st_r.wready;
	assign bvalid             = st_r.bvalid;
	assign bresp              = st_r.bresp;
	assign arready            = st_r.arready;
	assign rvalid             = st_r.rvalid;
	assign rresp              = st_r.rresp;
	assign rdata              = st_r.rdata;
	assign calendar_value     = st_r.cal_date;
	assign twelve_hour_select = st_r.twelve_hour;
	assign alarm_event_flag   = st_r.alarm_flag;

endmodule

// ===== testbench/rtc_calendar_alarm_chk.sv
// Port-level assertions for the calendar and alarm-match block.
`timescale 1ns/100ps
`include "rtc_cal_cfg.svh"

module rtc_calendar_alarm_chk (
	input wire logic        aclk,               // Clock.
	input wire logic        aresetn,            // Reset, active low.
	input wire logic        awvalid,            // Write address valid.
	input wire logic        awready,            // Write address ready.
	input wire logic        wvalid,             // Write data valid.
	input wire logic        wready,             // Write data ready.
	input wire logic        arvalid,            // Read address valid.
	input wire logic        arready,            // Read address ready.
	input wire logic [31:0] araddr,             // Read address.
	input wire logic        cal_load,           // Calendar load pulse.
	input wire logic [31:0] calendar_value,     // Calendar as held.
	input wire logic        twelve_hour_select, // Hour mode.
	input wire logic        alarm_event_flag    // Alarm flag.
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Any write beat taken; registers may only move after one.
	wire wr_take = awvalid && awready || wvalid && wready;

	// A calendar read with no load or write that could set the flag again.
	sequence cal_read;
		arvalid && arready && araddr == `ADDR_CAL_DATE && !cal_load && !awvalid && !wvalid;
	endsequence

	a_cal_reset: assert property (
		$rose(aresetn) |-> calendar_value == `CAL_DATE_RST) else $error("Calendar reset wrong.");
	a_mode_reset: assert property (
		$rose(aresetn) |-> !twelve_hour_select && !alarm_event_flag) else $error("Mode reset wrong.");
	a_century_rng: assert property (
		calendar_value[29:28] inside {`CT_MIN, `CT_MAX}) else $error("Century tens out of range.");
	a_digit_rng: assert property (
		calendar_value[27:24] <= 4'h9 && calendar_value[23:20] <= 4'h9 && calendar_value[19:16]
		<= 4'h9 && calendar_value[11:8] <= 4'h9 && calendar_value[6:3] <= 4'h9)
		else $error("Calendar digit out of range.");
	a_flag_set: assert property (
		calendar_value[30:0] != $past(calendar_value[30:0]) |-> calendar_value[31])
		else $error("Change flag not set.");
	a_flag_clear: assert property (
		cal_read |=> !calendar_value[31]) else $error("Change flag not cleared by read.");
	a_alarm_sticky: assert property (
		alarm_event_flag |=> alarm_event_flag) else $error("Alarm flag dropped.");
	a_mode_cause: assert property (
		twelve_hour_select != $past(twelve_hour_select) |-> $past(wr_take))
		else $error("Hour mode moved without a write.");
	a_cal_cause: assert property (
		calendar_value[30:0] != $past(calendar_value[30:0]) |-> $past(wr_take || cal_load))
		else $error("Calendar moved without a load.");
endmodule

bind rtc_calendar_alarm rtc_calendar_alarm_chk u_chk (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .arvalid, .arready, .araddr, .cal_load, .calendar_value,
	.twelve_hour_select, .alarm_event_flag);

// ===== testbench/rtc_calendar_alarm_tb.sv
// Self-checking bench for the calendar and alarm-match block.
`timescale 1ns/100ps
`include "rtc_cal_cfg.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end

module rtc_calendar_alarm_tb;
	logic        aclk = 0, aresetn = 0, ce = 1, cal_load = 0;  // Clock, reset, controls.
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0; // Bus strobes.
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, time_now = 0, cal_load_value = 0;
	logic [3:0]  wstrb = 4'hF;                              // Whole words only.
	logic        awready, wready, bvalid, arready, rvalid, twelve_hour_select, alarm_event_flag;
	logic [1:0]  bresp, rresp;                              // Response codes.
	logic [31:0] rdata, calendar_value;                     // Read data and calendar.
	int          error_cnt = 0, comparisons = 0, k;         // Counters.
	logic [31:0] seed = 32'h43C2, cal_m, ta_m, ca_m, r, d;  // Model registers.
	logic [5:0]  en_m;                                      // Model enables.
	logic        mode_m, flag_m;                            // Model mode and flag.
	int          dp [5] = '{24, 20, 16, 8, 3};              // Ten-valued digit positions.
	logic [31:0] kb [6] = '{32'h1, 32'h100, 32'h10000, 32'h1000000, 32'h100, 32'h8};
	logic [31:0] ad [8] = '{`ADDR_HOUR_MODE, `ADDR_CAL_DATE, `ADDR_TIME_ALARM, `ADDR_CAL_ALARM,
		`ADDR_ALARM_EN, `ADDR_EVENT_FLAGS, 32'h50000400, 32'h50000420};
	localparam logic [31:0] A = 32'h12345678, L = 32'h20241510;  // Legal time and date.

	rtc_calendar_alarm DUT (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .time_now, .cal_load, .cal_load_value, .calendar_value,
		.twelve_hour_select, .alarm_event_flag);

	always #4 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	// Xorshift source, so every run sees the same values.
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Calendar load model: bad digits keep the old one, any change raises the flag.
	function automatic logic [31:0] grd(logic [31:0] o, logic [31:0] n);
		grd = (o & 32'h80000000) | (n & `CAL_DATE_MASK);
		if (!(n[29:28] inside {2'h1, 2'h2}))
			grd[29:28] = o[29:28];
		foreach (dp[i])
			if (n[dp[i]+:4] > 4'h9)
				grd[dp[i]+:4] = o[dp[i]+:4];
		if (grd[30:0] != o[30:0])
			grd[31] = 1'b1;
	endfunction

	function automatic logic [1:0] rsp(logic [31:0] a);
		return (a inside {[`ADDR_HOUR_MODE:`ADDR_EVENT_FLAGS]}) && a != 32'h50000408 ?
			`RESP_OKAY : `RESP_SLVERR;
	endfunction

	task complete_run();
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// A handshake that never comes ends the run as a failure.
	task tmo();
		error_cnt++;
		$display("MISMATCH handshake exp 1 got 0");
		complete_run();
	endtask

	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		{cal_m, ta_m, ca_m, en_m, mode_m, flag_m} = {`CAL_DATE_RST, 72'h0};
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus write; address and data go out together and each drops once taken.
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic [1:0] rs;
		logic at, wt, bt;
		int n;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			{at, wt, bt, rs} = {awvalid && awready, wvalid && wready, bvalid, bresp};
			@(posedge aclk);
			if (at)
				awvalid <= 1'b0;
			if (wt)
				wvalid <= 1'b0;
			if (bt)
				break;
		end
		bready <= 1'b0;
		if (n == 50)
			tmo();
		`CHK("bresp", rsp(a), rs)
		case (a)
			`ADDR_HOUR_MODE: mode_m = v[0];
			`ADDR_CAL_DATE: cal_m = grd(cal_m, v);
			`ADDR_TIME_ALARM: ta_m = v & `TIME_ALARM_MASK;
			`ADDR_CAL_ALARM: ca_m = v & `CAL_ALARM_MASK;
			`ADDR_ALARM_EN: en_m = v[5:0];
			default: ;
		endcase
	endtask

	// Bus read compared with the model; a calendar read clears the model's flag.
	task automatic rd(input logic [31:0] a);
		logic [31:0] e, g;
		logic [1:0] rs;
		int n;
		@(negedge aclk);
		`CHK("calendar", cal_m, calendar_value)
		`CHK("mode", mode_m, twelve_hour_select)
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (n = 0; n < 50 && !(rvalid && rready); n++)
		begin
			@(negedge aclk);
			{g, rs} = {rdata, rresp};
			if (arvalid && arready)
				@(posedge aclk) arvalid <= 1'b0;
			else
				@(posedge aclk);
		end
		rready <= 1'b0;
		if (n == 50)
			tmo();
		case (a)
			`ADDR_HOUR_MODE: e = {31'h0, mode_m};
			`ADDR_CAL_DATE: e = cal_m;
			`ADDR_TIME_ALARM: e = ta_m;
			`ADDR_CAL_ALARM: e = ca_m;
			`ADDR_ALARM_EN: e = {26'h0, en_m};
			`ADDR_EVENT_FLAGS: e = {25'h0, flag_m, 6'h0};
			default: e = 32'h0;
		endcase
		`CHK("rdata", e, g)
		`CHK("rresp", rsp(a), rs)
		if (a == `ADDR_CAL_DATE)
			cal_m[31] = 1'b0;
	endtask

	// Presents a time and loads a calendar, then looks at the alarm flag.
	task automatic alm(input logic [31:0] t, input logic [31:0] c, input logic e);
		@(posedge aclk);
		time_now <= t;
		cal_load <= 1'b1;
		cal_load_value <= c;
		@(posedge aclk);
		cal_load <= 1'b0;
		cal_m = grd(cal_m, c);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		flag_m = e;
		`CHK("alarm", e, alarm_event_flag)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, random register traffic, then each alarm field on its own.
	initial
	begin
		rst();
		foreach (ad[i])
			rd(ad[i]);
		repeat (40)
		begin
			r = xs();
			d = xs();
			// Enables stay clear here so that no alarm fires in the middle of the traffic.
			if (ad[r[2:0]] == `ADDR_ALARM_EN)
				d[5:0] = 6'h0;
			wr(ad[r[2:0]], d);
			rd(ad[r[2:0]]);
			rd(`ADDR_CAL_DATE);
		end
		for (k = 0; k < 6; k++)
		begin
			rst();
			wr(`ADDR_TIME_ALARM, A);
			wr(`ADDR_CAL_ALARM, L);
			wr(`ADDR_ALARM_EN, 32'h1 << k);
			rd(`ADDR_ALARM_EN);
			alm(A ^ 32'h01010101, L ^ 32'h108, 1'b0);
			alm(A ^ (32'h01010101 & ~(k < 4 ? kb[k] : 0)),
				L ^ (32'h108 & ~(k < 4 ? 0 : kb[k])), 1'b1);
			alm(A ^ 32'h01010101, L ^ 32'h108, 1'b1);
			rd(`ADDR_EVENT_FLAGS);
		end
		rst();
		wr(`ADDR_HOUR_MODE, 32'h1);
		wr(`ADDR_TIME_ALARM, A | 32'h40000000);
		wr(`ADDR_ALARM_EN, 32'h8);
		alm(A, L, 1'b0);
		wr(`ADDR_HOUR_MODE, 32'h0);
		alm(A, L, 1'b1);
		rst();
		wr(`ADDR_TIME_ALARM, A);
		wr(`ADDR_CAL_ALARM, L);
		alm(A, L, 1'b0);
		// The time is moved off the alarm first, or the enable write itself would fire it.
		alm(A ^ 32'h1, L, 1'b0);
		wr(`ADDR_ALARM_EN, 32'h3F);
		rd(`ADDR_EVENT_FLAGS);
		alm(A, L, 1'b1);
		// A low clock enable must swallow a calendar load.
		@(posedge aclk) {ce, cal_load, cal_load_value} <= {2'b01, 32'h21000108};
		@(posedge aclk) {ce, cal_load} <= 2'b10;
		rd(`ADDR_CAL_DATE);
		complete_run();
	end
endmodule
